/* rtl/smbi_pkg.sv */
// How it works
// - cs1 set routes chip select 1 to dram
// - cs2 bit keeps static, enables slot two
// - cs3 bit keeps static, enables nand logic
// - cs4 bit keeps static, enables slot one
// - cleared bits leave plain static chip selects
// - bit 16 set connects wait pin
// - bit 16 clear frees wait pin for gpio
// - assignment register at offset zero, fixed decode
// - eight chip selects, 23-bit address bus
// - per-region 8 or 16-bit data width
// - separate strobes, two-cycle minimum access
// - active-low external wait input extends access
// - strobes and selects active low, data bidirectional
// - lowest pin is a0 or lower-byte select
// - write pins per-byte or enable plus upper
// - 8-bit uses a[22:0], 16-bit uses a[22:1]
// - address to chip-select page mapping fixed
// - small devices wrap inside their page
// - nand address/command latch from a21/a22
// - wait low during a static access freezes bus pins, counters and state
package smbi_pkg;

	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int XADDR_W = 23;
	localparam int NCS = 8;
	localparam int WS_W = 4;

	localparam logic [ADDR_W-1:0] OFS_CSA = 8'h00;
	localparam logic [ADDR_W-1:0] OFS_CSR_FIRST = 8'h10;
	localparam logic [ADDR_W-1:0] OFS_CSR_LAST = 8'h2C;

	localparam int CSA_DRAM_BIT = 1;
	localparam int CSA_SLOT2_BIT = 2;
	localparam int CSA_NAND_BIT = 3;
	localparam int CSA_SLOT1_BIT = 4;
	localparam int CSA_WAIT_BIT = 16;
	localparam logic [DATA_W-1:0] CSA_MASK = 32'h0001_001E;
	localparam logic [DATA_W-1:0] CSA_RESET = 32'h0000_0000;

	localparam int CSR_WIDE_BIT = 0;
	localparam int CSR_BSEL_BIT = 1;
	localparam int CSR_WS_LSB = 2;
	localparam logic [7:0] CSR_MASK = 8'h3F;
	localparam logic [7:0] CSR_RESET = 8'h01;

	localparam logic [3:0] PAGE_FIRST = 4'h1;
	localparam logic [3:0] PAGE_LAST = 4'h8;
	localparam int DRAM_CS = 1;
	localparam int SLOT2_CS = 2;
	localparam int NAND_CS = 3;
	localparam int SLOT1_CS = 4;
	localparam int ALE_BIT = 21;
	localparam int CLE_BIT = 22;

	typedef struct packed {
		logic [31:0] addr;
		logic write;
		logic half;
		logic [15:0] wdata;
	} smbi_acc_t;

	typedef struct packed {
		logic [NCS-1:0] chip_sel_n;
		logic rd_n;
		logic write_strobe_low_n;
		logic write_strobe_high_n;
		logic addr0_or_lower_byte_n;
		logic [XADDR_W-1:1] addr;
	} smbi_pins_t;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_ACCESS,
		ST_DRAM
	} smbi_state_t;

endpackage

/* rtl/smbi_static_memory_bus_interface.sv */
// Chosen here: strobed register access.
`timescale 1ns/10ps
module smbi_static_memory_bus_interface (
	input wire logic sys_clk_in,
	input wire logic arst_n_in,
	input wire logic [smbi_pkg::ADDR_W-1:0] reg_addr_in,
	input wire logic [smbi_pkg::DATA_W-1:0] reg_wdata_in,
	input wire logic reg_write_in,
	input wire logic reg_read_in,
	output logic [smbi_pkg::DATA_W-1:0] reg_rdata_out,
	input wire logic acc_req_in,
	input wire smbi_pkg::smbi_acc_t acc_in,
	output logic acc_busy_out,
	output logic acc_done_out,
	output logic [15:0] acc_rdata_out,
	output logic acc_error_out,
	output logic dram_req_out,
	output smbi_pkg::smbi_acc_t dram_acc_out,
	input wire logic dram_done_in,
	input wire logic [15:0] dram_rdata_in,
	output smbi_pkg::smbi_pins_t mem_pins_out,
	output logic [15:0] data_out,
	output logic data_oe_out,
	input wire logic [15:0] data_in,
	input wire logic wait_pin_n_in,
	output logic wait_pin_gpio_out,
	output logic nand_oe_n_out,
	output logic nand_we_n_out,
	output logic nand_ale_out,
	output logic nand_cle_out,
	output logic [1:0] card_cs_n_out,
	output logic card_rnw_out,
	output logic dram_route_sel_out,
	output logic card_slot1_enable_out,
	output logic card_slot2_enable_out,
	output logic nand_logic_enable_out
);

	////////////////////////////////////////////////////////////////////////////////
	// register file

	logic [smbi_pkg::DATA_W-1:0] csa_reg;
	logic [7:0] csr_reg [smbi_pkg::NCS];
	logic [smbi_pkg::DATA_W-1:0] rdata_reg;

	wire logic hit_csa = (reg_addr_in == smbi_pkg::OFS_CSA);
	wire logic hit_csr = (reg_addr_in >= smbi_pkg::OFS_CSR_FIRST) &&
		(reg_addr_in <= smbi_pkg::OFS_CSR_LAST) && (reg_addr_in[1:0] == 2'b00);
	wire logic [smbi_pkg::ADDR_W-1:0] csr_ofs = reg_addr_in - smbi_pkg::OFS_CSR_FIRST;
	wire logic [2:0] csr_idx = csr_ofs[4:2];
	wire logic dram_route_sel = csa_reg[smbi_pkg::CSA_DRAM_BIT];
	wire logic card_slot2_enable = csa_reg[smbi_pkg::CSA_SLOT2_BIT];
	wire logic nand_logic_enable = csa_reg[smbi_pkg::CSA_NAND_BIT];
	wire logic card_slot1_enable = csa_reg[smbi_pkg::CSA_SLOT1_BIT];
	wire logic wait_pin_connect = csa_reg[smbi_pkg::CSA_WAIT_BIT];
	wire logic [smbi_pkg::DATA_W-1:0] rd_mux = hit_csa ? csa_reg :
		hit_csr ? {24'h00_0000, csr_reg[csr_idx]} : '0;

	always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			csa_reg <= smbi_pkg::CSA_RESET;
			for (int i = 0; i < smbi_pkg::NCS; i++) begin
				csr_reg[i] <= smbi_pkg::CSR_RESET;
			end
			rdata_reg <= '0;
		end else begin
			if (reg_write_in && hit_csa) begin
				csa_reg <= reg_wdata_in & smbi_pkg::CSA_MASK;
			end
			if (reg_write_in && hit_csr) begin
				csr_reg[csr_idx] <= reg_wdata_in[7:0] & smbi_pkg::CSR_MASK;
			end
			rdata_reg <= reg_read_in ? rd_mux : '0;
		end
	end

	assign reg_rdata_out = rdata_reg;
	assign dram_route_sel_out = dram_route_sel;
	assign card_slot1_enable_out = card_slot1_enable;
	assign card_slot2_enable_out = card_slot2_enable;
	assign nand_logic_enable_out = nand_logic_enable;

	////////////////////////////////////////////////////////////////////////////////
	// wait pin routing and synchroniser

	logic wait_s1_reg;
	logic wait_s2_reg;
	wire logic wait_req_n = wait_pin_connect ? wait_pin_n_in : 1'b1;
	assign wait_pin_gpio_out = wait_pin_connect ? 1'b1 : wait_pin_n_in;

	always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			wait_s1_reg <= 1'b1;
			wait_s2_reg <= 1'b1;
		end else begin
			wait_s1_reg <= wait_req_n;
			wait_s2_reg <= wait_s1_reg;
		end
	end

	wire logic waiting = !wait_s2_reg;

	////////////////////////////////////////////////////////////////////////////////
	// fixed page decode

	function automatic logic page_valid(input logic [31:0] a);
		return (a[31:28] >= smbi_pkg::PAGE_FIRST) && (a[31:28] <= smbi_pkg::PAGE_LAST);
	endfunction

	function automatic logic [2:0] page_cs(input logic [31:0] a);
		logic [3:0] p;
		p = a[31:28] - smbi_pkg::PAGE_FIRST;
		return p[2:0];
	endfunction

	wire logic req_valid = page_valid(acc_in.addr);
	wire logic [2:0] req_cs = page_cs(acc_in.addr);
	wire logic req_dram = dram_route_sel && (req_cs == 3'(smbi_pkg::DRAM_CS));

	////////////////////////////////////////////////////////////////////////////////
	// access sequencer

	smbi_pkg::smbi_state_t state_reg;
	smbi_pkg::smbi_state_t state_next;
	smbi_pkg::smbi_acc_t cur_reg;
	logic [2:0] cs_reg;
	logic [smbi_pkg::WS_W-1:0] ws_reg;
	logic [smbi_pkg::WS_W-1:0] ws_next;
	logic done_reg;
	logic error_reg;
	logic [15:0] rdat_reg;
	logic dram_req_reg;
	// first access cycle: the registered pins are not on the bus yet
	logic lead_reg;

	wire logic [7:0] cur_cfg = csr_reg[cs_reg];
	wire logic cur_wide = cur_cfg[smbi_pkg::CSR_WIDE_BIT];
	wire logic cur_bsel = cur_cfg[smbi_pkg::CSR_BSEL_BIT];
	wire logic [smbi_pkg::WS_W-1:0] req_ws =
		csr_reg[req_cs][smbi_pkg::CSR_WS_LSB +: smbi_pkg::WS_W];
	wire logic take = acc_req_in && (state_reg == smbi_pkg::ST_IDLE);
	wire logic finish = (state_reg == smbi_pkg::ST_ACCESS) && !lead_reg && !waiting &&
		(ws_reg == '0);

	always_comb begin
		state_next = state_reg;
		ws_next = ws_reg;
		case (state_reg)
			smbi_pkg::ST_IDLE: begin
				if (take && req_valid) begin
					state_next = req_dram ? smbi_pkg::ST_DRAM : smbi_pkg::ST_ACCESS;
					ws_next = req_ws;
				end
			end
			smbi_pkg::ST_ACCESS: begin
				if (waiting) begin
					ws_next = ws_reg;
				end else if (ws_reg != '0) begin
					ws_next = ws_reg - 1'b1;
				end else if (!lead_reg) begin
					state_next = smbi_pkg::ST_IDLE;
				end
			end
			smbi_pkg::ST_DRAM: begin
				if (dram_done_in) begin
					state_next = smbi_pkg::ST_IDLE;
				end
			end
			default: begin
				state_next = smbi_pkg::ST_IDLE;
			end
		endcase
	end

	// lane choice of the halfword result
	wire logic [15:0] smc_rdata = (!cur_wide || (!cur_reg.half && cur_reg.addr[0])) ?
		(cur_wide ? {8'h00, data_in[15:8]} : {8'h00, data_in[7:0]}) : data_in;

	always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			state_reg <= smbi_pkg::ST_IDLE;
			cur_reg <= '0;
			cs_reg <= '0;
			ws_reg <= '0;
			done_reg <= 1'b0;
			error_reg <= 1'b0;
			rdat_reg <= '0;
			dram_req_reg <= 1'b0;
			lead_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			ws_reg <= ws_next;
			lead_reg <= take && req_valid && !req_dram;
			if (take) begin
				cur_reg <= acc_in;
				cs_reg <= req_cs;
			end
			dram_req_reg <= take && req_valid && req_dram;
			error_reg <= take && !req_valid;
			done_reg <= finish || (state_reg == smbi_pkg::ST_DRAM && dram_done_in) ||
				(take && !req_valid);
			if (finish && !cur_reg.write) begin
				rdat_reg <= smc_rdata;
			end else if (state_reg == smbi_pkg::ST_DRAM && dram_done_in) begin
				rdat_reg <= dram_rdata_in;
			end
		end
	end

	assign acc_busy_out = (state_reg != smbi_pkg::ST_IDLE);
	assign acc_done_out = done_reg;
	assign acc_error_out = error_reg;
	assign acc_rdata_out = rdat_reg;
	assign dram_req_out = dram_req_reg;
	assign dram_acc_out = cur_reg;

	////////////////////////////////////////////////////////////////////////////////
	// pin generation

	wire logic active = (state_reg == smbi_pkg::ST_ACCESS);
	wire logic lo_byte = cur_reg.half || !cur_reg.addr[0];
	wire logic hi_byte = cur_reg.half || cur_reg.addr[0];
	wire logic [15:0] wr_lanes = (cur_wide && !cur_reg.half && cur_reg.addr[0]) ?
		{cur_reg.wdata[7:0], 8'h00} : cur_reg.wdata;

	smbi_pkg::smbi_pins_t pins_next;

	always_comb begin
		pins_next = '0;
		pins_next.chip_sel_n = '1;
		pins_next.rd_n = 1'b1;
		pins_next.write_strobe_low_n = 1'b1;
		pins_next.write_strobe_high_n = 1'b1;
		pins_next.addr0_or_lower_byte_n = 1'b1;
		pins_next.addr = cur_reg.addr[smbi_pkg::XADDR_W-1:1];
		if (active) begin
			pins_next.chip_sel_n[cs_reg] = 1'b0;
			pins_next.rd_n = cur_reg.write;
			if (!cur_wide) begin
				pins_next.addr0_or_lower_byte_n = cur_reg.addr[0];
				pins_next.write_strobe_low_n = !cur_reg.write;
			end else if (cur_bsel) begin
				pins_next.addr0_or_lower_byte_n = !lo_byte;
				pins_next.write_strobe_high_n = !hi_byte;
				pins_next.write_strobe_low_n = !cur_reg.write;
			end else begin
				pins_next.write_strobe_low_n = !(cur_reg.write && lo_byte);
				pins_next.write_strobe_high_n = !(cur_reg.write && hi_byte);
			end
		end
	end

	logic data_oe_reg;
	logic [15:0] data_out_reg;
	smbi_pkg::smbi_pins_t pins_reg;

	always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			pins_reg <= {{smbi_pkg::NCS{1'b1}}, 4'hF, {(smbi_pkg::XADDR_W-1){1'b0}}};
			data_oe_reg <= 1'b0;
			data_out_reg <= '0;
		end else if (!waiting || !active) begin
			pins_reg <= pins_next;
			data_oe_reg <= active && cur_reg.write;
			data_out_reg <= wr_lanes;
		end
	end

	assign mem_pins_out = pins_reg;
	assign data_out = data_out_reg;
	assign data_oe_out = data_oe_reg;

	////////////////////////////////////////////////////////////////////////////////
	// nand and card add-on logic

	wire logic nand_hit = nand_logic_enable && !pins_reg.chip_sel_n[smbi_pkg::NAND_CS];
	assign nand_oe_n_out = nand_hit ? pins_reg.rd_n : 1'b1;
	assign nand_we_n_out = nand_hit ? pins_reg.write_strobe_low_n : 1'b1;
	assign nand_ale_out = nand_hit && pins_reg.addr[smbi_pkg::ALE_BIT];
	assign nand_cle_out = nand_hit && pins_reg.addr[smbi_pkg::CLE_BIT];
	assign card_cs_n_out[0] = card_slot1_enable ?
		pins_reg.chip_sel_n[smbi_pkg::SLOT1_CS] : 1'b1;
	assign card_cs_n_out[1] = card_slot2_enable ?
		pins_reg.chip_sel_n[smbi_pkg::SLOT2_CS] : 1'b1;
	assign card_rnw_out = !data_oe_reg;

endmodule // smbi_static_memory_bus_interface

/* tb/smbi_properties.sv */
`timescale 1ns/10ps
module smbi_properties (
	input wire logic sys_clk_in,
	input wire logic arst_n_in,
	input wire logic [smbi_pkg::ADDR_W-1:0] reg_addr_in,
	input wire logic [smbi_pkg::DATA_W-1:0] reg_wdata_in,
	input wire logic reg_write_in,
	input wire logic dram_req_out,
	input wire smbi_pkg::smbi_pins_t mem_pins_out,
	input wire logic wait_pin_n_in,
	input wire logic wait_pin_gpio_out,
	input wire logic nand_ale_out,
	input wire logic nand_cle_out,
	input wire logic [1:0] card_cs_n_out,
	input wire logic dram_route_sel_out,
	input wire logic card_slot1_enable_out,
	input wire logic card_slot2_enable_out,
	input wire logic nand_logic_enable_out
);
	logic conn_reg;
	logic [2:0] wlow_reg;
	wire logic csa_wr = reg_write_in && reg_addr_in == smbi_pkg::OFS_CSA;
	wire logic [7:0] cs_n = mem_pins_out.chip_sel_n;
	// shadow of the wait connect bit and a saturating count of low wait samples
	always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			conn_reg <= 1'b0;
			wlow_reg <= 3'h0;
		end else begin
			if (csa_wr) conn_reg <= reg_wdata_in[16];
			wlow_reg <= wait_pin_n_in ? 3'h0 : wlow_reg + {2'h0, wlow_reg != 3'h7};
		end
	end
	////////////////////////////////////////
	default clocking @(posedge sys_clk_in); endclocking
	default disable iff (!arst_n_in);
	AST_CSA_WR: assert property (csa_wr |=> {card_slot1_enable_out, nand_logic_enable_out,
		card_slot2_enable_out, dram_route_sel_out} == $past(reg_wdata_in[4:1]))
		else $error("assignment bits not loaded");
	AST_WAIT_CONN: assert property (conn_reg && $past(conn_reg) |-> wait_pin_gpio_out)
		else $error("wait pin still free while connected");
	AST_WAIT_FREE: assert property (!conn_reg && !$past(conn_reg) && !$past(conn_reg, 2)
		&& $stable(wait_pin_n_in) && $past(wait_pin_n_in, 2) == wait_pin_n_in
		|-> wait_pin_gpio_out == wait_pin_n_in) else $error("free wait pin not passed on");
	AST_ONE_CS: assert property ($onehot0(~cs_n))
		else $error("more than one chip select low");
	AST_DRAM: assert property (dram_req_out |-> dram_route_sel_out && cs_n[1])
		else $error("dram request without dram routing");
	AST_NAND: assert property (!cs_n[3] && nand_logic_enable_out |->
		nand_ale_out == mem_pins_out.addr[21] && nand_cle_out == mem_pins_out.addr[22])
		else $error("nand latch enables wrong");
	AST_SLOT1: assert property (card_cs_n_out[0] == (card_slot1_enable_out ? cs_n[4] : 1'b1))
		else $error("slot one select wrong");
	AST_SLOT2: assert property (card_cs_n_out[1] == (card_slot2_enable_out ? cs_n[2] : 1'b1))
		else $error("slot two select wrong");
	AST_FREEZE: assert property (conn_reg && $past(conn_reg) && wlow_reg >= 3'h6 |-> $stable(mem_pins_out))
		else $error("pins moved during wait");
endmodule // smbi_properties

bind smbi_static_memory_bus_interface smbi_properties smbi_properties_i (.*);

/* tb/smbi_mem_model.sv */
`timescale 1ns/10ps
module smbi_mem_model (
	input wire logic sys_clk_in,
	input wire logic slow_in,
	input wire smbi_pkg::smbi_pins_t pins_in,
	input wire logic [15:0] wdata_in,
	output logic [15:0] rdata_out,
	output logic wait_n_out
);
	logic [15:0] mem [256];
	logic [15:0] last_reg = 16'h0000;
	logic [2:0] hold_reg = 3'h0;
	logic used_reg = 1'b0;
	wire logic sel = !(&pins_in.chip_sel_n);
	wire logic [7:0] idx = pins_in.addr[8:1];
	// released bus shows a pattern that flips every cycle
	assign rdata_out = (sel && !pins_in.rd_n) ? mem[idx] : ~last_reg;
	assign wait_n_out = hold_reg == 3'h0;
	////////////////////////////////////////
	always @(posedge sys_clk_in) begin
		last_reg <= rdata_out;
		if (sel && !pins_in.write_strobe_low_n) mem[idx][7:0] <= wdata_in[7:0];
		if (sel && !pins_in.write_strobe_high_n) mem[idx][15:8] <= wdata_in[15:8];
		if (!sel) used_reg <= 1'b0;
		if (hold_reg != 3'h0) hold_reg <= hold_reg - 3'h1;
		else if (slow_in && sel && !used_reg && !(pins_in.rd_n && pins_in.write_strobe_low_n)) begin
			hold_reg <= 3'h6;
			used_reg <= 1'b1;
		end
	end
endmodule // smbi_mem_model

/* tb/smbi_static_memory_bus_interface_test.sv */
`timescale 1ns/10ps
module smbi_static_memory_bus_interface_test;
	logic sys_clk_in = 0, arst_n_in = 0, reg_write_in = 0, reg_read_in = 0, acc_req_in = 0;
	logic dram_done_in = 0, slow = 0, rd_d = 0, wait_pin_n_in;
	logic acc_busy_out, acc_done_out, acc_error_out, dram_req_out, data_oe_out, wait_pin_gpio_out;
	logic nand_oe_n_out, nand_we_n_out, nand_ale_out, nand_cle_out, card_rnw_out;
	logic dram_route_sel_out, card_slot1_enable_out, card_slot2_enable_out, nand_logic_enable_out;
	logic [7:0] reg_addr_in = 8'h00;
	logic [31:0] reg_wdata_in = 32'h0000_0000, reg_rdata_out, a, r;
	logic [15:0] acc_rdata_out, dram_rdata_in = 16'h0000, data_out, data_in, d;
	logic [1:0] card_cs_n_out;
	smbi_pkg::smbi_acc_t acc_in = '0, dram_acc_out;
	smbi_pkg::smbi_pins_t mem_pins_out;
	int fails = 0, n_tests = 0, seed = 36;
	logic [31:0] rq[$];
	logic [17:0] aq[$];
	smbi_static_memory_bus_interface smbi_static_memory_bus_interface_i (.*);
	smbi_mem_model smbi_mem_model_i (.sys_clk_in(sys_clk_in), .slow_in(slow), .pins_in(mem_pins_out),
		.wdata_in(data_out), .rdata_out(data_in), .wait_n_out(wait_pin_n_in));
	always #25 sys_clk_in = ~sys_clk_in;
	////////////////////////////////////////
	task final_report;
		if (fails == 0 && n_tests > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task cmp_reg(input logic [31:0] e);
		n_tests++;
		if (reg_rdata_out !== e) begin
			fails++;
			$display("mismatch %0t register read %h expected %h", $time, reg_rdata_out, e);
		end
	endtask
	task cmp_acc(input logic [17:0] e);
		n_tests++;
		if (acc_error_out !== e[17] || (e[16] && acc_rdata_out !== e[15:0])) begin
			fails++;
			$display("mismatch %0t access %b %h expected %h", $time, acc_error_out, acc_rdata_out, e);
		end
	endtask
	// register bus: w=0 reads and expects dd
	task bus(input logic w, input logic [7:0] ad, input logic [31:0] dd);
		if (!w) rq.push_back(dd);
		@(posedge sys_clk_in);
		reg_write_in <= w;
		reg_read_in <= !w;
		reg_addr_in <= ad;
		reg_wdata_in <= w ? dd : 32'h0000_0000;
		@(posedge sys_clk_in);
		reg_write_in <= 1'b0;
		reg_read_in <= 1'b0;
	endtask
	// e holds error, check-data flag and read data
	task acc(input logic [31:0] ad, input logic w, h, input logic [15:0] dd, input logic [17:0] e);
		aq.push_back(e);
		@(posedge sys_clk_in);
		acc_req_in <= 1'b1;
		acc_in <= '{ad, w, h, dd};
		do @(negedge sys_clk_in); while (acc_busy_out !== 1'b0);
		@(posedge sys_clk_in);
		acc_req_in <= 1'b0;
	endtask
	////////////////////////////////////////
	always @(posedge sys_clk_in) rd_d <= reg_read_in;
	always @(posedge sys_clk_in) dram_done_in <= dram_req_out;
	always @(negedge sys_clk_in) begin
		if (rd_d) cmp_reg(rq.pop_front());
		if (acc_done_out === 1'b1) cmp_acc(aq.size() ? aq.pop_front() : 18'h3_FFFF);
	end
	initial begin
		repeat (5000) @(posedge sys_clk_in);
		fails++;
		final_report;
	end
	initial begin
		dram_rdata_in = $random(seed);
		repeat (10) @(posedge sys_clk_in);
		arst_n_in <= 1'b1;
		bus(0, 8'h00, 32'h0000_0000);
		bus(1, 8'h04, 32'hFFFF_FFFF);
		bus(0, 8'h04, 32'h0000_0000);
		bus(0, 8'h70, 32'h0000_0000);
		bus(1, 8'h00, 32'hFFFF_FFFF);
		bus(0, 8'h00, smbi_pkg::CSA_MASK);
		repeat (4) begin
			r = $random(seed);
			bus(1, 8'h00, r);
			bus(0, 8'h00, r & smbi_pkg::CSA_MASK);
		end
		bus(1, 8'h00, 32'h0000_0000);
		for (int i = 0; i < 8; i++) begin
			r = $random(seed);
			d = $random(seed);
			a = {4'(i + 1), 5'h00, r[22:1], 1'b0};
			acc(a, 1'b1, 1'b1, d, 18'h0_0000);
			acc(a ^ 32'h0010_0000, 1'b0, 1'b1, 16'h0000, {2'b01, d});
		end
		acc(a, 1'b1, 1'b0, {2{r[7:0]}}, 18'h0_0000);
		acc(a | 32'h0000_0001, 1'b1, 1'b0, {2{r[15:8]}}, 18'h0_0000);
		acc(a, 1'b0, 1'b1, 16'h0000, {2'b01, r[15:0]});
		acc(32'h0000_0010, 1'b0, 1'b1, 16'h0000, 18'h2_0000);
		acc(32'h9000_0000, 1'b1, 1'b1, 16'h0000, 18'h2_0000);
		bus(1, 8'h00, 32'h0000_0002);
		acc(32'h2000_0100, 1'b0, 1'b1, 16'h0000, {2'b01, dram_rdata_in});
		// slots on: chip selects 2 and 4 stay static, card select follows the whole page
		bus(1, 8'h00, 32'h0000_001C);
		acc(32'h4060_0000, 1'b1, 1'b1, d, 18'h0_0000);
		acc(32'h5000_0002, 1'b0, 1'b1, 16'h0000, 18'h0_0000);
		acc(32'h3000_0004, 1'b0, 1'b1, 16'h0000, 18'h0_0000);
		bus(1, 8'h10, 32'h0000_0015);
		bus(1, 8'h00, 32'h0001_0000);
		slow <= 1'b1;
		acc(32'h1000_0040, 1'b1, 1'b1, d, 18'h0_0000);
		acc(32'h1000_0040, 1'b0, 1'b1, 16'h0000, {2'b01, d});
		bus(1, 8'h00, 32'h0000_0000);
		acc(32'h1000_0042, 1'b1, 1'b1, ~d, 18'h0_0000);
		acc(32'h1000_0042, 1'b0, 1'b1, 16'h0000, {2'b01, ~d});
		repeat (40) @(posedge sys_clk_in);
		if (aq.size() != 0) fails++;
		final_report;
	end
endmodule // smbi_static_memory_bus_interface_test
